// [dual_uart.v]
// Dual serial port: primary with flow control, log transmit-only port
`timescale 1ns/1ps
`include "uart_defines.vh"
module dual_uart (
	// Clock, reset, enable
	input wire mclk,
	input wire rst_b,
	input wire ce,
	// Configuration
	input wire xtal_is_26,
	input wire cfg_done,
	input wire [15:0] baud_div,
	input wire alt_pins,
	// Primary transmit data
	input wire tx_valid,
	output wire tx_ready,
	input wire [7:0] tx_data,
	// Primary receive data
	output reg rx_valid,
	output reg [7:0] rx_data,
	output reg rx_frame_err,
	// Log transmit data
	input wire log_valid,
	output reg log_ready,
	input wire [7:0] log_data,
	// Boot status character
	input wire boot_valid,
	input wire [7:0] boot_data,
	output reg boot_ready,
	// Primary pins
	input wire primary_receive_line,
	output reg primary_transmit_line,
	output reg primary_request_to_send,
	input wire primary_clear_to_send,
	// Alternate pins
	input wire alternate_pin_b,
	output reg alternate_pin_a,
	// Log pin
	output reg log_transmit_line
);
	localparam S_IDLE = 3'b001;
	localparam S_SHIFT = 3'b010;
	localparam S_STOP = 3'b100;
	// Two-flop synchronisers for pin inputs
	reg [1:0] rxd_sync_reg;
	reg [1:0] cts_sync_reg;
	reg [1:0] alt_sync_reg;
	wire rxd_s;
	wire cts_s;
	// FIFO between user and primary transmitter
	wire f_valid;
	wire f_ready;
	wire [7:0] f_data;
	// Primary transmitter
	reg [2:0] ptx_st_reg;
	reg [8:0] ptx_sh_reg;
	reg [3:0] ptx_bits_reg;
	reg [15:0] ptx_cnt_reg;
	reg ptx_line_reg;
	// Log transmitter
	reg [2:0] ltx_st_reg;
	reg [8:0] ltx_sh_reg;
	reg [3:0] ltx_bits_reg;
	reg [15:0] ltx_cnt_reg;
	// Receiver
	reg [2:0] rx_st_reg;
	reg [7:0] rx_sh_reg;
	reg [3:0] rx_bits_reg;
	reg [15:0] rx_cnt_reg;
	wire boot_mode;
	wire [15:0] div;
	wire ptx_take_boot;
	wire ptx_take_user;

	// Rate select shared by every engine
	function [15:0] pick_div;
		input boot;
		input x26;
		input [15:0] user;
		begin
			if (boot)
				pick_div = x26 ? `DIV_BOOT_26 : `DIV_BOOT_40;
			else if (user == `ZERO_DIV)
				pick_div = `DIV_MIN;
			else
				pick_div = user;
		end
	endfunction

	assign boot_mode = ~cfg_done;
	assign div = pick_div(boot_mode, xtal_is_26, baud_div);
	assign rxd_s = alt_pins ? alt_sync_reg[1] : rxd_sync_reg[1];
	assign cts_s = cts_sync_reg[1];
	assign ptx_take_boot = boot_mode & boot_valid;
	assign ptx_take_user = ~boot_mode & f_valid & ~cts_s;
	assign f_ready = (ptx_st_reg == S_IDLE) & ptx_take_user;

	uart_fifo #(
		.WIDTH(8),
		.DEPTH(`FIFO_DEPTH),
		.AW(`FIFO_AW)
	) u_fifo (
		.mclk(mclk),
		.rst_b(rst_b),
		.ce(ce),
		.in_valid(tx_valid),
		.in_ready(tx_ready),
		.in_data(tx_data),
		.out_valid(f_valid),
		.out_ready(f_ready),
		.out_data(f_data)
	);

	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rxd_sync_reg <= 2'h3;
			cts_sync_reg <= 2'h3;
			alt_sync_reg <= 2'h3;
		end
		else if (ce)
		begin
			rxd_sync_reg <= {rxd_sync_reg[0], primary_receive_line};
			cts_sync_reg <= {cts_sync_reg[0], primary_clear_to_send};
			alt_sync_reg <= {alt_sync_reg[0], alternate_pin_b};
		end
	end

	// Primary transmitter
	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ptx_st_reg <= S_IDLE;
			ptx_sh_reg <= 9'h1FF;
			ptx_bits_reg <= `ZERO_BITS;
			ptx_cnt_reg <= `ZERO_DIV;
			ptx_line_reg <= 1'b1;
			boot_ready <= 1'b0;
		end
		else if (ce)
		begin
			boot_ready <= 1'b0;
			case (ptx_st_reg)
			S_IDLE:
			begin
				ptx_line_reg <= 1'b1;
				ptx_cnt_reg <= div - 1'b1;
				ptx_bits_reg <= `ZERO_BITS;
				if (ptx_take_boot)
				begin
					ptx_sh_reg <= {boot_data, 1'b0};
					ptx_line_reg <= 1'b0;
					boot_ready <= 1'b1;
					ptx_st_reg <= S_SHIFT;
				end
				else if (ptx_take_user)
				begin
					ptx_sh_reg <= {f_data, 1'b0};
					ptx_line_reg <= 1'b0;
					ptx_st_reg <= S_SHIFT;
				end
			end
			S_SHIFT:
			begin
				if (ptx_cnt_reg == `ZERO_DIV)
				begin
					ptx_cnt_reg <= div - 1'b1;
					ptx_sh_reg <= {1'b1, ptx_sh_reg[8:1]};
					ptx_line_reg <= ptx_sh_reg[1];
					ptx_bits_reg <= ptx_bits_reg + 1'b1;
					if (ptx_bits_reg == `DATA_BITS)
					begin
						ptx_line_reg <= 1'b1;
						ptx_st_reg <= S_STOP;
					end
				end
				else
					ptx_cnt_reg <= ptx_cnt_reg - 1'b1;
			end
			S_STOP:
			begin
				if (ptx_cnt_reg == `ZERO_DIV)
					ptx_st_reg <= S_IDLE;
				else
					ptx_cnt_reg <= ptx_cnt_reg - 1'b1;
			end
			default:
				ptx_st_reg <= S_IDLE;
			endcase
		end
	end

	// Log transmitter, no receive side
	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ltx_st_reg <= S_IDLE;
			ltx_sh_reg <= 9'h1FF;
			ltx_bits_reg <= `ZERO_BITS;
			ltx_cnt_reg <= `ZERO_DIV;
			log_transmit_line <= 1'b1;
			log_ready <= 1'b0;
		end
		else if (ce)
		begin
			log_ready <= 1'b0;
			case (ltx_st_reg)
			S_IDLE:
			begin
				log_transmit_line <= 1'b1;
				ltx_cnt_reg <= div - 1'b1;
				ltx_bits_reg <= `ZERO_BITS;
				if (log_valid & ~log_ready)
				begin
					ltx_sh_reg <= {log_data, 1'b0};
					log_transmit_line <= 1'b0;
					log_ready <= 1'b1;
					ltx_st_reg <= S_SHIFT;
				end
			end
			S_SHIFT:
			begin
				if (ltx_cnt_reg == `ZERO_DIV)
				begin
					ltx_cnt_reg <= div - 1'b1;
					ltx_sh_reg <= {1'b1, ltx_sh_reg[8:1]};
					log_transmit_line <= ltx_sh_reg[1];
					ltx_bits_reg <= ltx_bits_reg + 1'b1;
					if (ltx_bits_reg == `DATA_BITS)
					begin
						log_transmit_line <= 1'b1;
						ltx_st_reg <= S_STOP;
					end
				end
				else
					ltx_cnt_reg <= ltx_cnt_reg - 1'b1;
			end
			S_STOP:
			begin
				if (ltx_cnt_reg == `ZERO_DIV)
					ltx_st_reg <= S_IDLE;
				else
					ltx_cnt_reg <= ltx_cnt_reg - 1'b1;
			end
			default:
				ltx_st_reg <= S_IDLE;
			endcase
		end
	end

	// Primary receiver, samples mid-bit
	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rx_st_reg <= S_IDLE;
			rx_sh_reg <= 8'h00;
			rx_bits_reg <= `ZERO_BITS;
			rx_cnt_reg <= `ZERO_DIV;
			rx_valid <= 1'b0;
			rx_data <= 8'h00;
			rx_frame_err <= 1'b0;
		end
		else if (ce)
		begin
			rx_valid <= 1'b0;
			rx_frame_err <= 1'b0;
			case (rx_st_reg)
			S_IDLE:
			begin
				rx_bits_reg <= `ZERO_BITS;
				rx_cnt_reg <= {1'b0, div[15:1]};
				if (~rxd_s)
					rx_st_reg <= S_SHIFT;
			end
			S_SHIFT:
			begin
				if (rx_cnt_reg == `ZERO_DIV)
				begin
					rx_cnt_reg <= div - 1'b1;
					rx_bits_reg <= rx_bits_reg + 1'b1;
					if (rx_bits_reg == `ZERO_BITS)
					begin
						if (rxd_s)
							rx_st_reg <= S_IDLE;
					end
					else
						rx_sh_reg <= {rxd_s, rx_sh_reg[7:1]};
					if (rx_bits_reg == `DATA_BITS)
						rx_st_reg <= S_STOP;
				end
				else
					rx_cnt_reg <= rx_cnt_reg - 1'b1;
			end
			S_STOP:
			begin
				if (rx_cnt_reg == `ZERO_DIV)
				begin
					rx_data <= rx_sh_reg;
					rx_valid <= rxd_s;
					rx_frame_err <= ~rxd_s;
					rx_st_reg <= S_IDLE;
				end
				else
					rx_cnt_reg <= rx_cnt_reg - 1'b1;
			end
			default:
				rx_st_reg <= S_IDLE;
			endcase
		end
	end

	// Pin routing and receive flow control
	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			primary_transmit_line <= 1'b1;
			alternate_pin_a <= 1'b1;
			primary_request_to_send <= 1'b1;
		end
		else if (ce)
		begin
			// Alternate route keeps the normal pin idle during boot text
			primary_transmit_line <= alt_pins ? 1'b1 : ptx_line_reg;
			alternate_pin_a <= alt_pins ? ptx_line_reg : 1'b1;
			// RTS low (ready) only when receiver idle; no receive buffer
			primary_request_to_send <= ~(rx_st_reg == S_IDLE) | boot_mode;
		end
	end
endmodule

// [uart_defines.vh]
// Constants for the dual serial port block
`ifndef UART_DEFINES_VH
`define UART_DEFINES_VH
`define CLK_HZ 250000000
`define BAUD_BASE 115200
`define BAUD_MULT_MAX 40
`define XTAL_40_BOOT_BAUD 115200
`define XTAL_26_BOOT_BAUD 74880
`define DIV_W 16
`define DIV_BOOT_40 16'h087A
`define DIV_BOOT_26 16'h0D0B
`define DIV_MIN 16'h0001
`define BIT_CNT_W 4
`define FRAME_BITS 4'h9
`define DATA_BITS 4'h8
`define DATA_MSB 7
`define FIFO_DEPTH 4
`define FIFO_AW 2
`define ZERO_DIV 16'h0000
`define ZERO_BITS 4'h0
`endif

// [uart_fifo.v]
// Small valid/ready FIFO for serial data
`timescale 1ns/1ps
module uart_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 4,
	parameter AW = 2
)(
	// Clock, reset and enable
	input wire mclk,
	input wire rst_b,
	input wire ce,
	// Fill side
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	// Drain side
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_reg;
	reg [AW-1:0] rd_reg;
	reg [AW:0] cnt_reg;
	reg ready_reg;
	wire push;
	wire pop;
	// Registered so the top-level ready comes straight from a flop
	assign in_ready = ready_reg;
	assign out_valid = (cnt_reg != {(AW+1){1'b0}});
	assign out_data = mem[rd_reg];
	assign push = in_valid & in_ready & ce;
	assign pop = out_valid & out_ready & ce;
	always @(posedge mclk)
	begin
		if (push)
			mem[wr_reg] <= in_data;
	end
	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wr_reg <= {AW{1'b0}};
			rd_reg <= {AW{1'b0}};
			cnt_reg <= {(AW+1){1'b0}};
			ready_reg <= 1'b1;
		end
		else
		begin
			if (push)
				wr_reg <= wr_reg + 1'b1;
			if (pop)
				rd_reg <= rd_reg + 1'b1;
			if (push & ~pop)
			begin
				cnt_reg <= cnt_reg + 1'b1;
				ready_reg <= (cnt_reg + 1'b1 != DEPTH[AW:0]);
			end
			else if (pop & ~push)
			begin
				cnt_reg <= cnt_reg - 1'b1;
				ready_reg <= 1'b1;
			end
		end
	end
endmodule

// [uart_chk_asserts.sv]
// Pin-level checks for the dual serial port
`timescale 1ns/1ps
module uart_chk (
	// Clock and reset
	input wire mclk,
	input wire rst_b,
	// Watched ports
	input wire cfg_done,
	input wire alt_pins,
	input wire log_ready,
	input wire log_transmit_line,
	input wire boot_ready,
	input wire primary_transmit_line,
	input wire primary_request_to_send,
	input wire rx_valid,
	input wire rx_frame_err
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);
	// A take must be followed by 8 cycles with no further take
	sequence s_quiet(x);
		!x [*8];
	endsequence
	a_log_start: assert property (log_ready |-> !log_transmit_line)
		else $error("log start bit missing");
	a_log_gap: assert property (log_ready |=> s_quiet(log_ready))
		else $error("log byte taken mid frame");
	a_boot_start: assert property (boot_ready && !alt_pins
		|=> !primary_transmit_line) else $error("boot start bit missing");
	a_boot_mode: assert property (boot_ready |-> !$past(cfg_done))
		else $error("boot byte taken in user mode");
	a_boot_gap: assert property (boot_ready |=> s_quiet(boot_ready))
		else $error("boot byte taken mid frame");
	a_rts_boot: assert property (!cfg_done [*3] |-> primary_request_to_send)
		else $error("receive ready during boot");
	a_rx_pulse: assert property (rx_valid |=> !rx_valid)
		else $error("receive strobe too long");
	a_err_pulse: assert property (rx_frame_err |=> !rx_frame_err)
		else $error("frame error strobe too long");
endmodule
bind dual_uart uart_chk chk (.*);

// [serial_peer.sv]
// Far-side serial terminal: frame receiver and sender
`timescale 1ns/1ps
module serial_peer (
	// Clock
	input wire mclk,
	// Serial lines
	input wire sin,
	input wire rts,
	output reg sout,
	output reg cts
);
	initial sout = 1'b1;
	initial cts = 1'b0;
	// Mid-bit sampling tolerates a small divisor error
	task automatic get(input int div, output logic [7:0] b, output logic ok);
		int n;
		n = 0;
		ok = 1'b0;
		b = 8'h00;
		while (sin !== 1'b0 && n < 40000)
		begin
			@(posedge mclk);
			n++;
		end
		repeat (div / 2) @(posedge mclk);
		if (sin === 1'b0)
		begin
			for (int i = 0; i < 8; i++)
			begin
				repeat (div) @(posedge mclk);
				b[i] = sin;
			end
			repeat (div) @(posedge mclk);
			ok = (sin === 1'b1);
		end
	endtask
	task automatic put(input int div, input logic [7:0] b, input logic stop);
		int n;
		n = 0;
		while (rts !== 1'b0 && n < 4000)
		begin
			@(posedge mclk);
			n++;
		end
		sout <= 1'b0;
		repeat (div) @(posedge mclk);
		for (int i = 0; i < 8; i++)
		begin
			sout <= b[i];
			repeat (div) @(posedge mclk);
		end
		sout <= stop;
		repeat (div) @(posedge mclk);
		sout <= 1'b1;
		repeat (div) @(posedge mclk);
	endtask
endmodule

// [testbench.sv]
// Self-checking bench for the dual serial port
`timescale 1ns/1ps
`include "uart_defines.vh"
module testbench;
	int div = `CLK_HZ / (`BAUD_BASE * `BAUD_MULT_MAX);
	int fails = 0;
	int n_compared = 0;
	int cyc = 0;
	logic mclk = 1'b0, rst_b = 1'b0, ce = 1'b1, xtal_is_26 = 1'b0;
	logic cfg_done = 1'b0, alt_pins = 1'b0, watch_log = 1'b0;
	logic tx_valid = 1'b0, log_valid = 1'b0, boot_valid = 1'b0;
	logic [7:0] tx_data = 8'h00, log_data = 8'h00, boot_data = 8'h00;
	logic [15:0] baud_div;
	wire tx_ready, rx_valid, rx_frame_err, log_ready, boot_ready;
	wire [7:0] rx_data;
	wire primary_transmit_line, primary_request_to_send, alternate_pin_a;
	wire log_transmit_line, sout, cts;
	wire mon = watch_log ? log_transmit_line :
		alt_pins ? alternate_pin_a : primary_transmit_line;
	wire primary_receive_line = alt_pins ? 1'b1 : sout;
	wire alternate_pin_b = alt_pins ? sout : 1'b1;
	wire primary_clear_to_send = cts;
	dual_uart dut (.*);
	serial_peer p (.mclk(mclk), .sin(mon), .rts(primary_request_to_send),
		.sout(sout), .cts(cts));
	always #2 mclk = ~mclk;
	task automatic check(input string what, input logic [15:0] e,
		input logic [15:0] s);
		n_compared++;
		if (s !== e)
		begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", what, e, s);
		end
	endtask
	task automatic hs(input logic boot, input logic [7:0] b);
		int n;
		n = 0;
		boot_valid <= boot;
		log_valid <= !boot;
		boot_data <= b;
		log_data <= b;
		@(posedge mclk);
		while ((boot ? boot_ready : log_ready) !== 1'b1 && n < 4000)
		begin
			@(posedge mclk);
			n++;
		end
		boot_valid <= 1'b0;
		log_valid <= 1'b0;
	endtask
	task automatic t_boot(input logic x26, input int bd);
		logic [7:0] b;
		logic ok;
		int n;
		n = 0;
		xtal_is_26 <= x26;
		hs(1'b1, 8'hA5);
		// Start bit is isolated since the first data bit is high
		fork
			p.get(bd, b, ok);
			begin
				while (mon !== 1'b0)
					@(posedge mclk);
				while (mon === 1'b0)
				begin
					n++;
					@(posedge mclk);
				end
			end
		join
		check("boot byte", 8'hA5, b);
		check("boot stop", 1'b1, ok);
		check("boot bit", bd[15:0], n[15:0]);
		repeat (bd) @(posedge mclk);
	endtask
	task automatic t_log();
		logic [7:0] b;
		logic ok;
		watch_log = 1'b1;
		ce <= 1'b0;
		log_valid <= 1'b1;
		log_data <= 8'hC1;
		repeat (4) @(posedge mclk);
		check("frozen line", 1'b1, log_transmit_line);
		ce <= 1'b1;
		for (int i = 0; i < 2; i++)
		begin
			hs(1'b0, 8'hC1 ^ i[7:0]);
			p.get(div, b, ok);
			check("log byte", 8'hC1 ^ i[7:0], b);
			check("log stop", 1'b1, ok);
		end
		watch_log = 1'b0;
	endtask
	task automatic t_fifo();
		logic [7:0] b;
		logic ok;
		int n;
		n = 0;
		p.cts <= 1'b1;
		repeat (3) @(posedge mclk);
		tx_valid <= 1'b1;
		tx_data <= 8'h10;
		repeat (8)
		begin
			@(posedge mclk);
			if (tx_ready === 1'b1)
				n++;
			tx_data <= 8'h10 + n[7:0];
		end
		tx_valid <= 1'b0;
		check("fifo fill", 16'h0004, n[15:0]);
		check("held line", 1'b1, primary_transmit_line);
		p.cts <= 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			p.get(div, b, ok);
			check("fifo byte", 8'h10 + i[7:0], b);
		end
	endtask
	task automatic t_rx(input logic [7:0] b, input logic stop);
		int n;
		logic busy;
		n = 0;
		busy = 1'b0;
		check("rts idle", 1'b0, primary_request_to_send);
		fork
			p.put(div, b, stop);
		join_none
		while (rx_valid !== 1'b1 && rx_frame_err !== 1'b1 && n < 1000)
		begin
			@(posedge mclk);
			busy |= primary_request_to_send;
			n++;
		end
		check("rx error", !stop, rx_frame_err);
		check("rts busy", 1'b1, busy);
		if (stop)
			check("rx data", b, rx_data);
		wait fork;
	endtask
	task automatic t_alt();
		logic [7:0] b;
		logic ok;
		t_rx(8'h3C, 1'b1);
		tx_valid <= 1'b1;
		tx_data <= 8'hC3;
		@(posedge mclk);
		check("alt ready", 1'b1, tx_ready);
		tx_valid <= 1'b0;
		p.get(div, b, ok);
		check("alt byte", 8'hC3, b);
	endtask
	task automatic final_report();
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Ceiling covers both slow boot frames plus the user traffic
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 90000)
		begin
			fails++;
			final_report();
		end
	end
	initial
	begin
		baud_div = div[15:0];
		repeat (5) @(posedge mclk);
		rst_b <= 1'b1;
		@(posedge mclk);
		t_boot(1'b0, (`CLK_HZ + `XTAL_40_BOOT_BAUD / 2) / `XTAL_40_BOOT_BAUD);
		t_boot(1'b1, (`CLK_HZ + `XTAL_26_BOOT_BAUD / 2) / `XTAL_26_BOOT_BAUD);
		cfg_done <= 1'b1;
		t_log();
		t_fifo();
		t_rx(8'h96, 1'b1);
		t_rx(8'h5A, 1'b0);
		alt_pins <= 1'b1;
		@(posedge mclk);
		t_alt();
		final_report();
	end
endmodule
